/* sbp_defs.svh */
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

// Register offsets inside one socket window
`define SBP_OFF_TXSIZE 8'h1F
`define SBP_OFF_FSR_H 8'h20
`define SBP_OFF_FSR_L 8'h21
`define SBP_OFF_TXRD_H 8'h22
`define SBP_OFF_TXRD_L 8'h23
`define SBP_OFF_TXWR_H 8'h24
`define SBP_OFF_TXWR_L 8'h25
`define SBP_OFF_RSR_H 8'h26
`define SBP_OFF_RSR_L 8'h27
`define SBP_OFF_RXRD_H 8'h28
`define SBP_OFF_RXRD_L 8'h29
`define SBP_OFF_RXWR_H 8'h2A
`define SBP_OFF_RXWR_L 8'h2B
`define SBP_OFF_IMR 8'h2C
`define SBP_OFF_FRAG_H 8'h2D
`define SBP_OFF_FRAG_L 8'h2E
`define SBP_OFF_OPT2 8'h2F

// Reset values
`define SBP_RST_TXSIZE 8'h02
`define SBP_RST_FSR 16'h0800
`define SBP_RST_PTR 16'h0000
`define SBP_RST_IMR 8'hFF
`define SBP_RST_FRAG 16'h4000
`define SBP_RST_OPT2 8'h00

// Field positions and masks
`define SBP_IMR_RSVD 3'h7
`define SBP_OPT2_MASK 8'h73
`define SBP_OPT2_BCAST_RAW 6
`define SBP_OPT2_MCAST_RAW 5
`define SBP_OPT2_V6_RAW 4
`define SBP_OPT2_BCAST_PUSH 1
`define SBP_OPT2_UNICAST 0
`define SBP_KB_SHIFT 10
`define SBP_FIFO_DEPTH 16

`endif

/* sbp_mem_model.sv */
`timescale 1ns/1ns

module sbp_mem_model (
  // Clock
  input wire logic clk,
  // Receive buffer write port
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] data,
  output logic ready,
  // Pacing: 0 prompt, 1 slow, 2 held off
  input wire logic [1:0] pace
);
  logic [23:0] got_q[$];
  logic [1:0] ph = 2'h0;

  // Ready moves on the rising edge, so it never races the pacing input
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    ready <= (pace == 2'h0) || (pace == 2'h1 && ph == 2'h3);
  end

  // A write counts only once it is held to an edge that sees ready high
  always @(posedge clk) begin
    if (we && ready) begin
      got_q.push_back({addr, data});
    end
  end
endmodule

/* sbp_pkg.sv */
package sbp_pkg;

  typedef enum logic [3:0] {
    SBP_MODE_CLOSED = 4'h0,
    SBP_MODE_TCP = 4'h1,
    SBP_MODE_UDP = 4'h2,
    SBP_MODE_RAW_IP_MODE = 4'h3,
    SBP_MODE_RAWFRAME = 4'h4
  } sbp_mode_type;

  typedef enum logic [1:0] {
    SBP_RX_IDLE = 2'b00,
    SBP_RX_PASS = 2'b01,
    SBP_RX_DROP = 2'b10
  } sbp_rxst_type;

  typedef struct packed {
    logic [15:0] len;
    logic bcast;
    logic mcast;
    logic ipv6;
    logic unicast;
  } sbp_rx_desc_type;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } sbp_byte_type;

endpackage

/* sbp_regs.sv */
`timescale 1ns/1ns
`include "sbp_defs.svh"

module sbp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  always_comb begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      in_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // Ready is a flop, computed from the next fill level, so it is never late
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

module sbp_regs
  import sbp_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Host register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Socket engine events
  input wire sbp_mode_type SOCK_MODE,
  input wire logic SOCK_MCAST,
  input wire logic OPEN_CMD,
  input wire logic RECEIVE_DONE_CMD_CMD,
  input wire logic TCP_PTR_LOAD,
  input wire logic [15:0] TCP_PTR_VALUE,
  input wire logic TCP_ACK_VALID,
  input wire logic [15:0] TCP_ACK_PTR,
  input wire logic TX_DONE,
  output logic TX_DONE_FLAG_SET,
  output logic TCP_FORCE_PUSH,
  output logic [4:0] IRQ_ENABLE,
  output logic [15:0] IP_FRAG_FIELD,
  // Buffer memory map
  input wire logic [15:0] TX_BASE_IN,
  output logic [15:0] TX_REGION_BASE,
  output logic [15:0] TX_REGION_END,
  output logic [15:0] TX_ADDR_MASK,
  input wire logic [15:0] RX_BASE_IN,
  input wire logic [7:0] RX_SIZE_CODE,
  // Receive descriptor and bytes
  input wire sbp_rx_desc_type RX_DESC,
  input wire logic RX_DESC_VALID,
  output logic RX_DESC_READY,
  input wire sbp_byte_type RX_DATA,
  input wire logic RX_DATA_VALID,
  output logic RX_DATA_READY,
  // Receive buffer write port
  output logic RXMEM_WE,
  output logic [15:0] RXMEM_ADDR,
  output logic [7:0] RXMEM_DATA,
  input wire logic RXMEM_READY
);
  logic [7:0] tx_size_q;
  logic [15:0] fsr_q;
  logic [15:0] tx_rd_q;
  logic [15:0] tx_wr_q;
  logic [15:0] ack_q;
  logic [15:0] rsr_q;
  logic [15:0] rx_rd_q;
  logic [15:0] rx_rd_used_q;
  logic [15:0] rx_wr_q;
  logic [15:0] wp_q;
  logic [7:0] imr_q;
  logic [15:0] frag_q;
  logic [7:0] opt2_q;
  logic opened_q;
  sbp_rxst_type st_q;
  logic mem_last_q;
  logic [15:0] fsr_ref;
  logic [15:0] fsr_calc;
  logic [15:0] rsr_calc;
  logic [16:0] rx_room;
  logic [15:0] rx_mask;
  logic blocked;
  logic wr_sz;
  logic [7:0] rd_mux;
  logic fifo_valid;
  logic fifo_ready;
  sbp_byte_type fifo_out;
  logic mem_take;
  logic desc_take;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a >= b) ? (a - b) : (b - a);
  endfunction

  function automatic logic legal_size(input logic [7:0] c);
    legal_size = (c == 8'h00) || (c == 8'h01) || (c == 8'h02) || (c == 8'h04) || (c == 8'h08);
  endfunction

  // TCP frees space only once the peer acknowledges it
  assign fsr_ref = (SOCK_MODE == SBP_MODE_TCP) ? ack_q : tx_rd_q;
  assign fsr_calc = absdiff(tx_wr_q, fsr_ref) + 16'h0001;
  assign rsr_calc = absdiff(rx_wr_q, rx_rd_used_q);
  // Widen the code before shifting so the kilobyte scale is not lost
  assign rx_mask = ({8'h00, RX_SIZE_CODE} << `SBP_KB_SHIFT) - 16'h0001;
  assign rx_room = {1'b0, ({8'h00, RX_SIZE_CODE} << `SBP_KB_SHIFT)} - {1'b0, rsr_q};
  assign wr_sz = REG_WE && (REG_ADDR == `SBP_OFF_TXSIZE);

  always_comb begin
    blocked = (SOCK_MODE == SBP_MODE_CLOSED);
    if (SOCK_MODE == SBP_MODE_RAWFRAME) begin
      blocked = (opt2_q[`SBP_OPT2_BCAST_RAW] && RX_DESC.bcast) ||
                (opt2_q[`SBP_OPT2_MCAST_RAW] && RX_DESC.mcast) ||
                (opt2_q[`SBP_OPT2_V6_RAW] && RX_DESC.ipv6);
    end else if (SOCK_MODE == SBP_MODE_UDP) begin
      blocked = (opt2_q[`SBP_OPT2_BCAST_PUSH] && RX_DESC.bcast) ||
                (SOCK_MCAST && opt2_q[`SBP_OPT2_UNICAST] && RX_DESC.unicast);
    end
  end

  // Size code register and region map
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_size_q <= `SBP_RST_TXSIZE;
      TX_REGION_BASE <= `SBP_RST_PTR;
      TX_REGION_END <= `SBP_RST_PTR;
      TX_ADDR_MASK <= `SBP_RST_PTR;
    end else begin
      // Illegal codes are ignored so the region map never takes an odd size
      if (wr_sz && legal_size(REG_WDATA)) begin
        tx_size_q <= REG_WDATA;
      end
      TX_REGION_BASE <= TX_BASE_IN;
      TX_REGION_END <= TX_BASE_IN + ({8'h00, tx_size_q} << `SBP_KB_SHIFT);
      TX_ADDR_MASK <= ({8'h00, tx_size_q} << `SBP_KB_SHIFT) - 16'h0001;
    end
  end

  // Transmit pointers
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_wr_q <= `SBP_RST_PTR;
      tx_rd_q <= `SBP_RST_PTR;
      ack_q <= `SBP_RST_PTR;
      TX_DONE_FLAG_SET <= 1'b0;
    end else begin
      TX_DONE_FLAG_SET <= TX_DONE;
      if (REG_WE && REG_ADDR == `SBP_OFF_TXWR_H) begin
        tx_wr_q[15:8] <= REG_WDATA;
      end
      if (REG_WE && REG_ADDR == `SBP_OFF_TXWR_L) begin
        tx_wr_q[7:0] <= REG_WDATA;
      end
      if (OPEN_CMD) begin
        tx_rd_q <= tx_wr_q;
        ack_q <= tx_wr_q;
      end else if (TCP_PTR_LOAD) begin
        tx_rd_q <= TCP_PTR_VALUE;
        ack_q <= TCP_PTR_VALUE;
      end else begin
        if (TX_DONE) begin
          tx_rd_q <= tx_wr_q;
        end
        if (TCP_ACK_VALID) begin
          ack_q <= TCP_ACK_PTR;
        end
      end
    end
  end

  // The free size report holds its reset value until the socket is activated; the receive size follows its pointers from reset
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      opened_q <= 1'b0;
      fsr_q <= `SBP_RST_FSR;
      rsr_q <= `SBP_RST_PTR;
    end else begin
      if (OPEN_CMD) begin
        opened_q <= 1'b1;
      end else if (SOCK_MODE == SBP_MODE_CLOSED) begin
        opened_q <= 1'b0;
      end
      if (opened_q) begin
        fsr_q <= fsr_calc;
      end
      rsr_q <= rsr_calc;
    end
  end

  // Receive read pointer: host copy and the copy that frees space
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_rd_q <= `SBP_RST_PTR;
      rx_rd_used_q <= `SBP_RST_PTR;
    end else begin
      if (REG_WE && REG_ADDR == `SBP_OFF_RXRD_H) begin
        rx_rd_q[15:8] <= REG_WDATA;
      end
      if (REG_WE && REG_ADDR == `SBP_OFF_RXRD_L) begin
        rx_rd_q[7:0] <= REG_WDATA;
      end
      if (RECEIVE_DONE_CMD_CMD) begin
        rx_rd_used_q <= rx_rd_q;
      end
    end
  end

  // Option registers
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      imr_q <= `SBP_RST_IMR;
      frag_q <= `SBP_RST_FRAG;
      opt2_q <= `SBP_RST_OPT2;
      IRQ_ENABLE <= 5'(`SBP_RST_IMR);
      IP_FRAG_FIELD <= `SBP_RST_FRAG;
      TCP_FORCE_PUSH <= 1'b0;
    end else begin
      if (REG_WE && REG_ADDR == `SBP_OFF_IMR) begin
        imr_q <= {`SBP_IMR_RSVD, REG_WDATA[4:0]};
      end
      if (REG_WE && REG_ADDR == `SBP_OFF_FRAG_H) begin
        frag_q[15:8] <= REG_WDATA;
      end
      if (REG_WE && REG_ADDR == `SBP_OFF_FRAG_L) begin
        frag_q[7:0] <= REG_WDATA;
      end
      if (REG_WE && REG_ADDR == `SBP_OFF_OPT2) begin
        opt2_q <= REG_WDATA & `SBP_OPT2_MASK;
      end
      IRQ_ENABLE <= imr_q[4:0];
      IP_FRAG_FIELD <= frag_q;
      TCP_FORCE_PUSH <= (SOCK_MODE == SBP_MODE_TCP) && opt2_q[`SBP_OPT2_BCAST_PUSH];
    end
  end

  always_comb begin
    unique case (REG_ADDR)
      `SBP_OFF_TXSIZE: rd_mux = tx_size_q;
      `SBP_OFF_FSR_H: rd_mux = fsr_q[15:8];
      `SBP_OFF_FSR_L: rd_mux = fsr_q[7:0];
      `SBP_OFF_TXRD_H: rd_mux = tx_rd_q[15:8];
      `SBP_OFF_TXRD_L: rd_mux = tx_rd_q[7:0];
      `SBP_OFF_TXWR_H: rd_mux = tx_wr_q[15:8];
      `SBP_OFF_TXWR_L: rd_mux = tx_wr_q[7:0];
      `SBP_OFF_RSR_H: rd_mux = rsr_q[15:8];
      `SBP_OFF_RSR_L: rd_mux = rsr_q[7:0];
      `SBP_OFF_RXRD_H: rd_mux = rx_rd_q[15:8];
      `SBP_OFF_RXRD_L: rd_mux = rx_rd_q[7:0];
      `SBP_OFF_RXWR_H: rd_mux = rx_wr_q[15:8];
      `SBP_OFF_RXWR_L: rd_mux = rx_wr_q[7:0];
      `SBP_OFF_IMR: rd_mux = imr_q;
      `SBP_OFF_FRAG_H: rd_mux = frag_q[15:8];
      `SBP_OFF_FRAG_L: rd_mux = frag_q[7:0];
      `SBP_OFF_OPT2: rd_mux = opt2_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      REG_RDATA <= rd_mux;
    end
  end

  // Receive path: bytes queue in the FIFO while the descriptor is judged
  sbp_fifo #(
    .WIDTH($bits(sbp_byte_type)),
    .DEPTH(`SBP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .in_valid(RX_DATA_VALID),
    .in_data(RX_DATA),
    .in_ready(RX_DATA_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_out),
    .out_ready(fifo_ready)
  );

  assign mem_take = RXMEM_WE && RXMEM_READY;
  assign desc_take = RX_DESC_VALID && RX_DESC_READY;
  assign fifo_ready = (st_q == SBP_RX_DROP) || ((st_q == SBP_RX_PASS) && (!RXMEM_WE || RXMEM_READY));

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= SBP_RX_IDLE;
      RX_DESC_READY <= 1'b0;
    end else begin
      unique case (st_q)
        SBP_RX_IDLE: begin
          // Wait for the last write to land so the room check sees the new fill level
          RX_DESC_READY <= !RXMEM_WE;
          if (desc_take) begin
            RX_DESC_READY <= 1'b0;
            // Too large or filtered packets are consumed but never stored
            if (blocked || ({1'b0, RX_DESC.len} > rx_room)) begin
              st_q <= SBP_RX_DROP;
            end else begin
              st_q <= SBP_RX_PASS;
            end
          end
        end
        SBP_RX_PASS, SBP_RX_DROP: begin
          RX_DESC_READY <= 1'b0;
          if (fifo_valid && fifo_ready && fifo_out.last) begin
            st_q <= SBP_RX_IDLE;
          end
        end
        default: begin
          st_q <= SBP_RX_IDLE;
          RX_DESC_READY <= 1'b0;
        end
      endcase
    end
  end

  // Memory writes stand until accepted; the pointer commits on the last byte
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RXMEM_WE <= 1'b0;
      RXMEM_ADDR <= `SBP_RST_PTR;
      RXMEM_DATA <= 8'h00;
      mem_last_q <= 1'b0;
      wp_q <= `SBP_RST_PTR;
      rx_wr_q <= `SBP_RST_PTR;
    end else begin
      if (OPEN_CMD) begin
        wp_q <= rx_wr_q;
      end else if (st_q == SBP_RX_PASS && fifo_valid && fifo_ready) begin
        RXMEM_WE <= 1'b1;
        RXMEM_ADDR <= RX_BASE_IN + (wp_q & rx_mask);
        RXMEM_DATA <= fifo_out.data;
        mem_last_q <= fifo_out.last;
        wp_q <= wp_q + 16'h0001;
      end else if (mem_take) begin
        RXMEM_WE <= 1'b0;
      end
      if (mem_take && mem_last_q) begin
        rx_wr_q <= wp_q;
      end
    end
  end

  tx_size_legal_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    wr_sz && !legal_size(REG_WDATA) |=> $stable(tx_size_q))
    else $error("illegal transmit size code was stored");

  region_chain_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $stable(tx_size_q) && $stable(TX_BASE_IN) |=> TX_REGION_END == TX_REGION_BASE + ({8'h00, $past(tx_size_q)} << 10))
    else $error("transmit region end does not follow its base");

  free_size_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    opened_q && SOCK_MODE != SBP_MODE_TCP |=> fsr_q == absdiff($past(tx_wr_q), $past(tx_rd_q)) + 16'h0001)
    else $error("free size differs from pointer distance plus one");

  open_init_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    OPEN_CMD |=> tx_rd_q == $past(tx_wr_q) ##1 fsr_q == 16'h0001 || SOCK_MODE == SBP_MODE_TCP || $past(REG_WE, 2))
    else $error("activate did not initialise transmit read pointer");

  tx_done_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    TX_DONE && !OPEN_CMD && !TCP_PTR_LOAD |=> TX_DONE_FLAG_SET && tx_rd_q == $past(tx_wr_q))
    else $error("transmit done did not advance read pointer and flag");

  receive_done_cmd_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !RECEIVE_DONE_CMD_CMD |=> $stable(rx_rd_used_q))
    else $error("receive read pointer freed space without command");

  rx_commit_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !(mem_take && mem_last_q) |=> $stable(rx_wr_q))
    else $error("receive write pointer moved outside a packet end");

  imr_rsvd_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    REG_RE && REG_ADDR == `SBP_OFF_IMR |=> REG_RDATA[7:5] == 3'b111)
    else $error("reserved enable bits did not read as ones");

  raw_block_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    desc_take && SOCK_MODE == SBP_MODE_RAWFRAME && opt2_q[6] && RX_DESC.bcast |=> st_q == SBP_RX_DROP [*1])
    else $error("blocked broadcast frame was not dropped");

  force_push_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    SOCK_MODE == SBP_MODE_TCP && opt2_q[1] |=> TCP_FORCE_PUSH)
    else $error("push flag not forced in TCP mode");
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
`include "sbp_defs.svh"

module tb_top
  import sbp_pkg::*;
();
  localparam int RXCAP = 1024;
  logic clk, rstn, we, re, open_c, receive_done_cmd_c, pl, av, txd, mc, dv, bv;
  logic flag, push, de_rdy, dt_rdy, mwe, mrdy;
  logic [7:0] ad, wd, rdata, rsz, mdat;
  logic [15:0] pv, ap, tbase, rb, seed, frag, rbase, rend, rmask, maddr;
  logic [4:0] irq;
  logic [1:0] pace;
  sbp_mode_type md;
  sbp_rx_desc_type desc;
  sbp_byte_type bt;
  int n_fail, total_checks, txwr, txrd, ack, rxwr, rxfree, cur;
  logic [7:0] rv [19] = '{8'h00, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h40, 8'h00, 8'h00, 8'h00};

  sbp_regs sbp_regs_inst (.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(ad), .REG_WE(we), .REG_RE(re),
    .REG_WDATA(wd), .REG_RDATA(rdata), .SOCK_MODE(md), .SOCK_MCAST(mc), .OPEN_CMD(open_c),
    .RECEIVE_DONE_CMD_CMD(receive_done_cmd_c), .TCP_PTR_LOAD(pl), .TCP_PTR_VALUE(pv), .TCP_ACK_VALID(av), .TCP_ACK_PTR(ap),
    .TX_DONE(txd), .TX_DONE_FLAG_SET(flag), .TCP_FORCE_PUSH(push), .IRQ_ENABLE(irq),
    .IP_FRAG_FIELD(frag), .TX_BASE_IN(tbase), .TX_REGION_BASE(rbase), .TX_REGION_END(rend),
    .TX_ADDR_MASK(rmask), .RX_BASE_IN(rb), .RX_SIZE_CODE(rsz), .RX_DESC(desc),
    .RX_DESC_VALID(dv), .RX_DESC_READY(de_rdy), .RX_DATA(bt), .RX_DATA_VALID(bv),
    .RX_DATA_READY(dt_rdy), .RXMEM_WE(mwe), .RXMEM_ADDR(maddr), .RXMEM_DATA(mdat),
    .RXMEM_READY(mrdy));

  sbp_mem_model sbp_mem_model_inst (.clk(clk), .we(mwe), .addr(maddr), .data(mdat), .ready(mrdy),
    .pace(pace));

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic [15:0] absd(input int a, input int b, input int k);
    return 16'(((a > b) ? a - b : b - a) + k);
  endfunction

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ad = a;
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask

  // Two back-to-back reads one clock apart, high byte first; the low byte is not latched with the high byte
  task automatic cr(input string nm, input logic [7:0] a, input logic [15:0] e, input bit w);
    logic [15:0] v;
    repeat (3) @(negedge clk);
    ad = a;
    re = 1'b1;
    @(negedge clk);
    v[15:8] = rdata;
    ad = a + 8'h01;
    @(negedge clk);
    v[7:0] = rdata;
    re = 1'b0;
    chk16(nm, e, w ? v : {8'h00, v[15:8]});
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic pkt(input sbp_mode_type m, input logic c, input logic [7:0] o, input logic [3:0] f,
    input int n, input bit ok);
    int base;
    logic [7:0] b;
    logic [23:0] eq[$];
    md = m;
    mc = c;
    wr(`SBP_OFF_OPT2, o);
    base = sbp_mem_model_inst.got_q.size();
    @(negedge clk);
    desc = {16'(n), f};
    dv = 1'b1;
    while (de_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    dv = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      eq.push_back({16'(rb + ((rxwr + i) & (RXCAP - 1))), b});
      bt = {i == n - 1, b};
      bv = 1'b1;
      while (dt_rdy !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    bv = 1'b0;
    while (de_rdy !== 1'b1 || sbp_mem_model_inst.got_q.size() < base + (ok ? n : 0)) @(negedge clk);
    repeat (4) @(negedge clk);
    chk16("mem writes", 16'(base + (ok ? n : 0)), 16'(sbp_mem_model_inst.got_q.size()));
    for (int i = 0; ok && i < n; i++) begin
      chk16("mem addr", eq[i][23:8], sbp_mem_model_inst.got_q[base + i][23:8]);
      chk16("mem data", {8'h00, eq[i][7:0]}, {8'h00, sbp_mem_model_inst.got_q[base + i][7:0]});
    end
    if (ok) rxwr = (rxwr + n) % 65536;
    cr("rx write ptr", `SBP_OFF_RXWR_H, 16'(rxwr), 1);
    cr("rx size", `SBP_OFF_RSR_H, absd(rxwr, rxfree, 0), 1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog exp done got hang");
    end_sim();
  end

  initial begin
    {rstn, we, re, open_c, receive_done_cmd_c, pl, av, txd, mc, dv, bv} = '0;
    {ad, wd, pv, ap, tbase} = '0;
    {n_fail, total_checks, rxwr, rxfree} = '0;
    rb = 16'hC000;
    rsz = 8'h01;
    pace = 2'h0;
    md = SBP_MODE_CLOSED;
    desc = '0;
    bt = '0;
    seed = 16'd18427;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk16("irq out", 16'h001F, {11'h000, irq});
    chk16("frag out", 16'h4000, frag);
    foreach (rv[i]) cr("reset byte", 8'h1E + 8'(i), {8'h00, rv[i]}, 0);
    $display("reset test done");
    cur = 2;
    for (int c = 0; c < 10; c++) begin
      tbase = rnd();
      wr(`SBP_OFF_TXSIZE, 8'(c));
      if (c inside {0, 1, 2, 4, 8}) cur = c;
      cr("tx size", `SBP_OFF_TXSIZE, 16'(cur), 0);
      chk16("region base", tbase, rbase);
      chk16("region end", 16'(tbase + cur * 1024), rend);
      chk16("region mask", 16'(cur * 1024 - 1), rmask);
    end
    $display("size test done");
    wr(`SBP_OFF_IMR, 8'h00);
    cr("irq en", `SBP_OFF_IMR, 16'h00E0, 0);
    chk16("irq out", 16'h0000, {11'h000, irq});
    wr(`SBP_OFF_IMR, 8'h15);
    cr("irq en", `SBP_OFF_IMR, 16'h00F5, 0);
    chk16("irq out", 16'h0015, {11'h000, irq});
    pv = rnd();
    w16(`SBP_OFF_FRAG_H, pv);
    cr("frag", `SBP_OFF_FRAG_H, pv, 1);
    chk16("frag out", pv, frag);
    md = SBP_MODE_TCP;
    wr(`SBP_OFF_OPT2, 8'hFF);
    cr("options", `SBP_OFF_OPT2, 16'h0073, 0);
    chkb("push", 1'b1, push);
    md = SBP_MODE_UDP;
    repeat (2) @(negedge clk);
    chkb("push", 1'b0, push);
    $display("field test done");
    txwr = 16'h0123;
    w16(`SBP_OFF_TXWR_H, 16'(txwr));
    cr("free", `SBP_OFF_FSR_H, 16'h0800, 1);
    pulse(open_c);
    txrd = txwr;
    cr("tx rd", `SBP_OFF_TXRD_H, 16'(txrd), 1);
    for (int k = 0; k < 4; k++) begin
      txwr = rnd();
      w16(`SBP_OFF_TXWR_H, 16'(txwr));
      cr("free", `SBP_OFF_FSR_H, absd(txwr, txrd, 1), 1);
    end
    wr(`SBP_OFF_TXRD_H, 8'hFF);
    wr(`SBP_OFF_FSR_H, 8'hFF);
    cr("tx rd", `SBP_OFF_TXRD_H, 16'(txrd), 1);
    cr("free", `SBP_OFF_FSR_H, absd(txwr, txrd, 1), 1);
    @(negedge clk);
    txd = 1'b1;
    @(negedge clk);
    txd = 1'b0;
    chkb("done flag", 1'b1, flag);
    @(negedge clk);
    chkb("done flag", 1'b0, flag);
    txrd = txwr;
    cr("tx rd", `SBP_OFF_TXRD_H, 16'(txrd), 1);
    cr("free", `SBP_OFF_FSR_H, 16'h0001, 1);
    md = SBP_MODE_TCP;
    pv = rnd();
    pulse(pl);
    txrd = pv;
    cr("tx rd", `SBP_OFF_TXRD_H, 16'(txrd), 1);
    ap = rnd();
    pulse(av);
    ack = ap;
    cr("free", `SBP_OFF_FSR_H, absd(txwr, ack, 1), 1);
    cr("tx rd", `SBP_OFF_TXRD_H, 16'(txrd), 1);
    $display("transmit test done");
    pkt(SBP_MODE_UDP, 1'b0, 8'h00, 4'b0001, 5, 1);
    pkt(SBP_MODE_RAWFRAME, 1'b0, 8'h40, 4'b1000, 3, 0);
    pkt(SBP_MODE_RAWFRAME, 1'b0, 8'h00, 4'b1000, 3, 1);
    pkt(SBP_MODE_RAWFRAME, 1'b0, 8'h20, 4'b0100, 3, 0);
    pkt(SBP_MODE_RAWFRAME, 1'b0, 8'h10, 4'b0010, 3, 0);
    pkt(SBP_MODE_UDP, 1'b0, 8'h02, 4'b1000, 4, 0);
    pkt(SBP_MODE_UDP, 1'b1, 8'h01, 4'b0001, 4, 0);
    pkt(SBP_MODE_UDP, 1'b1, 8'h00, 4'b0001, 2, 1);
    pkt(SBP_MODE_RAW_IP_MODE, 1'b0, 8'h70, 4'b1110, 2, 1);
    pkt(SBP_MODE_CLOSED, 1'b0, 8'h00, 4'b0001, 2, 0);
    pace = 2'h1;
    pkt(SBP_MODE_UDP, 1'b0, 8'h02, 4'b0001, 6, 1);
    pace = 2'h2;
    fork
      pkt(SBP_MODE_UDP, 1'b0, 8'h00, 4'b0001, 24, 1);
      begin
        repeat (60) @(negedge clk);
        chkb("fifo ready", 1'b0, dt_rdy);
        pace = 2'h0;
      end
    join
    pkt(SBP_MODE_UDP, 1'b0, 8'h00, 4'b0001, RXCAP - rxwr, 1);
    pkt(SBP_MODE_UDP, 1'b0, 8'h00, 4'b0001, 1, 0);
    w16(`SBP_OFF_RXRD_H, 16'(rxwr));
    cr("rx size", `SBP_OFF_RSR_H, absd(rxwr, rxfree, 0), 1);
    pulse(receive_done_cmd_c);
    rxfree = rxwr;
    cr("rx size", `SBP_OFF_RSR_H, 16'h0000, 1);
    cr("rx rd", `SBP_OFF_RXRD_H, 16'(rxwr), 1);
    pkt(SBP_MODE_UDP, 1'b0, 8'h00, 4'b0001, 7, 1);
    $display("receive test done");
    end_sim();
  end
endmodule
